//--- logic/chp_consts.svh
// offsets, field positions, reset values and fixed codes of the codec host register port
`ifndef CHP_CONSTS_SVH
`define CHP_CONSTS_SVH

// register_select_lines values
`define CHP_SEL_INDEX 2'h0
`define CHP_SEL_DATA 2'h1
`define CHP_SEL_STATUS 2'h2
`define CHP_SEL_PIO 2'h3

// indirect_index values held in this block
`define CHP_IX_LEFT_INPUT 4'h0
`define CHP_IX_RIGHT_INPUT 4'h1
`define CHP_IX_LEFT_AUX1 4'h2
`define CHP_IX_RIGHT_AUX1 4'h3

// reset values, and the bytes read while initializing and from an unmapped index
`define CHP_RST_INPUT_CTRL 8'h00
`define CHP_RST_AUX1_CTRL 8'h80
`define CHP_RST_STATUS 8'hCC
`define CHP_RST_INDEX 4'h0
`define CHP_INIT_READ 8'h80
`define CHP_UNMAPPED_READ 8'h00

// index register field
`define CHP_IDX_INIT_BIT 7

// status register fields
`define CHP_ST_INT 0
`define CHP_ST_PLAYBACK_BYTE_READY 1
`define CHP_ST_PCHAN 2
`define CHP_ST_PHALF 3
`define CHP_ST_SAMPLE_OVERRUN_UNDERRUN 4
`define CHP_ST_CAPTURE_BYTE_READY 5
`define CHP_ST_CCHAN 6
`define CHP_ST_CHALF 7

// input control fields
`define CHP_IN_GAIN_LSB 0
`define CHP_IN_GAIN_MSB 3
`define CHP_IN_BOOST_BIT 5
`define CHP_IN_SRC_LSB 6
`define CHP_IN_SRC_MSB 7
`define CHP_IN_WMASK 8'hEF

// aux1 control fields
`define CHP_AX_LEVEL_LSB 0
`define CHP_AX_LEVEL_MSB 4
`define CHP_AX_MUTE_BIT 7
`define CHP_AX_WMASK 8'h9F

`endif

//--- logic/chp_pkg.sv
// types of the codec host register port
package chp_pkg;

    typedef enum logic [2:0] {
        CHP_BUS_IDLE = 3'b001,
        CHP_BUS_READ = 3'b010,
        CHP_BUS_WRITE = 3'b100
    } chp_bus_state_e;

    typedef logic [2:0] chp_count_t;

endpackage

//--- logic/chp_codec_host_port.sv
// host register port of the stereo codec: data window, status, pio bytes, input and aux1 controls
`timescale 1ns/10ps
`include "chp_consts.svh"
// Operation
// RULE_01: select 1 accesses the indexed register
// RULE_02: initializing: window ignores writes, reads 80h
// RULE_03: interrupt flag sticky, any status write clears
// RULE_04: interrupt pin shows flag when gate on
// RULE_05: only counter underflow sets the flag
// RULE_06: playback ready when byte register may load
// RULE_07: playback side bit: 0 right, 1 left/mono
// RULE_08: playback half: 0 lower, 1 upper/8-bit
// RULE_09: over/underrun bit updated every sample
// RULE_10: capture ready when byte data fresh
// RULE_11: capture side and half bits reported
// RULE_12: ready/interrupt bits may rise during reads
// RULE_13: status resets to 1100 1100
// RULE_14: select 3: writes playback, reads capture
// RULE_15: initializing: pio writes ignored, reads 80h
// RULE_16: capture reads advance, hold on last byte
// RULE_17: playback writes advance, extras ignored, reset on take
// RULE_18: host writes index, then uses window
// RULE_19: input gain 4 bits and mic boost
// RULE_20: source select per channel, reset zero
// RULE_21: aux1 level 5 bits, 8 is unity
// RULE_22: aux1 mute bit 7, reset 80h
// RULE_23: index low four bits readable and writable
module chp_codec_host_port
    import chp_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // host bus pins
    input wire logic host_cs_n_in,
    input wire logic host_rd_n_in,
    input wire logic host_wr_n_in,
    input wire logic [1:0] register_select_lines_in,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe_out,
    output logic irq_out,
    // codec core state
    input wire logic init_busy_in,
    input wire logic irq_pin_gate_in,
    input wire logic counter_underflow_in,
    input wire logic eight_bit_mode_in,
    input wire logic stereo_mode_in,
    input wire logic playback_pio_enable_in,
    input wire logic capture_pio_enable_in,
    input wire logic capture_overrun_flag_in,
    input wire logic playback_underrun_flag_in,
    input wire logic sample_tick_in,
    // capture sample from the converters
    input wire logic capture_sample_in,
    input wire logic [15:0] capture_left_in,
    input wire logic [15:0] capture_right_in,
    // playback sample to the converters
    input wire logic playback_take_in,
    output logic [15:0] playback_left_out,
    output logic [15:0] playback_right_out,
    // control fields
    output logic [3:0] indirect_index_out,
    output logic [3:0] left_input_gain_out,
    output logic [3:0] right_input_gain_out,
    output logic left_mic_boost_out,
    output logic right_mic_boost_out,
    output logic [1:0] left_source_select_out,
    output logic [1:0] right_source_select_out,
    output logic [4:0] left_aux1_level_out,
    output logic [4:0] right_aux1_level_out,
    output logic left_aux1_mute_out,
    output logic right_aux1_mute_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic chp_count_t bytes_needed(input logic eight, input logic stereo);
        chp_count_t n;
        n = eight ? 3'h1 : 3'h2;
        bytes_needed = stereo ? chp_count_t'({n[1:0], 1'b0}) : n;
    endfunction

    // left when mono or still in the first half of the sample
    function automatic logic side_bit(input chp_count_t cnt, input logic eight, input logic stereo);
        chp_count_t half;
        half = eight ? 3'h1 : 3'h2;
        side_bit = !stereo || (cnt < half);
    endfunction

    function automatic logic half_bit(input chp_count_t cnt, input logic eight);
        half_bit = eight || cnt[0];
    endfunction

    // byte position inside {right, left}; 8-bit data sits in the upper byte of each word
    function automatic logic [1:0] byte_slot(input chp_count_t cnt, input logic eight, input logic stereo);
        logic right;
        right = !side_bit(cnt, eight, stereo);
        byte_slot = {right, eight | cnt[0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: stage 1 feeds stage 2 only, stage 3 is an edge history and also supplies write select and write data

    localparam int PW = 13;
    logic [PW-1:0] pin_s1_r;
    logic [PW-1:0] pin_s2_r;
    logic [PW-1:0] pin_s3_r;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            pin_s1_r <= 13'h1C00;
            pin_s2_r <= 13'h1C00;
            pin_s3_r <= 13'h1C00;
        end else begin
            pin_s1_r <= {host_cs_n_in, host_rd_n_in, host_wr_n_in, register_select_lines_in, host_data_in};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    logic rd_start;
    logic wr_end;
    logic [1:0] rd_sel;
    logic [1:0] wr_sel;
    logic [7:0] wr_data;

    assign rd_start = !pin_s2_r[12] && !pin_s2_r[11] && pin_s3_r[11];
    assign wr_end = !pin_s3_r[12] && pin_s2_r[10] && !pin_s3_r[10];
    assign rd_sel = pin_s2_r[9:8];
    assign wr_sel = pin_s3_r[9:8];
    assign wr_data = pin_s3_r[7:0];

    logic win_wr;
    logic status_wr;
    logic pio_wr;
    logic pio_rd;
    assign win_wr = wr_end && wr_sel == `CHP_SEL_DATA && !init_busy_in;       // see RULE_01, see RULE_02
    assign status_wr = wr_end && wr_sel == `CHP_SEL_STATUS;
    assign pio_wr = wr_end && wr_sel == `CHP_SEL_PIO && !init_busy_in;        // see RULE_14, see RULE_15
    assign pio_rd = rd_start && rd_sel == `CHP_SEL_PIO && !init_busy_in;

    ////////////////////////////////////////////////////////////////////////////////
    // host cycle tracking and output enable

    chp_bus_state_e bus_r;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            bus_r <= CHP_BUS_IDLE;
        end else begin
            case (bus_r)
                CHP_BUS_IDLE: begin
                    if (rd_start) begin
                        bus_r <= CHP_BUS_READ;
                    end else if (!pin_s2_r[12] && !pin_s2_r[10]) begin
                        bus_r <= CHP_BUS_WRITE;
                    end
                end
                CHP_BUS_READ: begin
                    if (pin_s2_r[11] || pin_s2_r[12]) begin
                        bus_r <= CHP_BUS_IDLE;
                    end
                end
                CHP_BUS_WRITE: begin
                    if (pin_s2_r[10]) begin
                        bus_r <= CHP_BUS_IDLE;
                    end
                end
                default: bus_r <= CHP_BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            host_data_oe_out <= 1'b0;
        end else begin
            host_data_oe_out <= (bus_r == CHP_BUS_READ) && !pin_s2_r[11] && !pin_s2_r[12];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // index and indirect control registers

    logic [7:0] left_input_r;
    logic [7:0] right_input_r;
    logic [7:0] left_aux1_r;
    logic [7:0] right_aux1_r;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            indirect_index_out <= `CHP_RST_INDEX;
        end else if (wr_end && wr_sel == `CHP_SEL_INDEX && !init_busy_in) begin
            indirect_index_out <= wr_data[3:0];                               // see RULE_23, see RULE_18
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            left_input_r <= `CHP_RST_INPUT_CTRL;                              // see RULE_20
            right_input_r <= `CHP_RST_INPUT_CTRL;
            left_aux1_r <= `CHP_RST_AUX1_CTRL;                                // see RULE_22
            right_aux1_r <= `CHP_RST_AUX1_CTRL;
        end else if (win_wr) begin
            case (indirect_index_out)
                `CHP_IX_LEFT_INPUT: left_input_r <= wr_data & `CHP_IN_WMASK;  // see RULE_19
                `CHP_IX_RIGHT_INPUT: right_input_r <= wr_data & `CHP_IN_WMASK;
                `CHP_IX_LEFT_AUX1: left_aux1_r <= wr_data & `CHP_AX_WMASK;    // see RULE_21
                `CHP_IX_RIGHT_AUX1: right_aux1_r <= wr_data & `CHP_AX_WMASK;
                default: ;
            endcase
        end
    end

    assign left_input_gain_out = left_input_r[`CHP_IN_GAIN_MSB:`CHP_IN_GAIN_LSB];
    assign right_input_gain_out = right_input_r[`CHP_IN_GAIN_MSB:`CHP_IN_GAIN_LSB];
    assign left_mic_boost_out = left_input_r[`CHP_IN_BOOST_BIT];
    assign right_mic_boost_out = right_input_r[`CHP_IN_BOOST_BIT];
    assign left_source_select_out = left_input_r[`CHP_IN_SRC_MSB:`CHP_IN_SRC_LSB];
    assign right_source_select_out = right_input_r[`CHP_IN_SRC_MSB:`CHP_IN_SRC_LSB];
    assign left_aux1_level_out = left_aux1_r[`CHP_AX_LEVEL_MSB:`CHP_AX_LEVEL_LSB];
    assign right_aux1_level_out = right_aux1_r[`CHP_AX_LEVEL_MSB:`CHP_AX_LEVEL_LSB];
    assign left_aux1_mute_out = left_aux1_r[`CHP_AX_MUTE_BIT];
    assign right_aux1_mute_out = right_aux1_r[`CHP_AX_MUTE_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt flag and pin

    logic int_flag_r;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            int_flag_r <= 1'b0;
        end else begin
            // a new underflow beats a coincident clearing write
            int_flag_r <= counter_underflow_in || (int_flag_r && !status_wr);  // see RULE_03, see RULE_05
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= int_flag_r && irq_pin_gate_in;                           // see RULE_04
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // capture byte tracker

    chp_count_t need;
    assign need = bytes_needed(eight_bit_mode_in, stereo_mode_in);

    logic [31:0] cap_word_r;
    chp_count_t cap_cnt_r;
    logic cap_fresh_r;
    logic [7:0] cap_byte;
    assign cap_byte = cap_word_r[8*byte_slot(cap_cnt_r, eight_bit_mode_in, stereo_mode_in) +: 8];

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            cap_word_r <= 32'h0000_0000;
            cap_cnt_r <= 3'h0;
            cap_fresh_r <= 1'b0;
        end else if (capture_sample_in) begin
            cap_word_r <= {capture_right_in, capture_left_in};
            cap_cnt_r <= 3'h0;                                                  // see RULE_16
            cap_fresh_r <= capture_pio_enable_in;
        end else if (pio_rd) begin
            if (cap_cnt_r + 3'h1 < need) begin
                cap_cnt_r <= cap_cnt_r + 3'h1;                                  // see RULE_16
            end else begin
                cap_fresh_r <= 1'b0;                                            // see RULE_10
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // playback byte tracker

    logic [31:0] pb_word_r;
    chp_count_t pb_cnt_r;
    chp_count_t pb_eff;
    logic pb_accept;
    assign pb_eff = playback_take_in ? 3'h0 : pb_cnt_r;
    assign pb_accept = pio_wr && pb_eff < need;                                 // see RULE_17

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            pb_word_r <= 32'h0000_0000;
        end else if (pb_accept) begin
            pb_word_r[8*byte_slot(pb_eff, eight_bit_mode_in, stereo_mode_in) +: 8] <= wr_data;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            pb_cnt_r <= 3'h0;
        end else begin
            pb_cnt_r <= pb_accept ? pb_eff + 3'h1 : pb_eff;                     // see RULE_17
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            playback_left_out <= 16'h0000;
            playback_right_out <= 16'h0000;
        end else if (playback_take_in) begin
            playback_left_out <= pb_word_r[15:0];
            playback_right_out <= stereo_mode_in ? pb_word_r[31:16] : pb_word_r[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status register, sampled so a host read sees one consistent snapshot

    logic [7:0] status_r;
    logic sample_overrun_underrun_r;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            sample_overrun_underrun_r <= 1'b0;
        end else if (sample_tick_in) begin
            sample_overrun_underrun_r <= capture_overrun_flag_in || playback_underrun_flag_in;     // see RULE_09
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            status_r <= `CHP_RST_STATUS;                                        // see RULE_13
        end else begin
            status_r[`CHP_ST_INT] <= int_flag_r;
            status_r[`CHP_ST_PLAYBACK_BYTE_READY] <= playback_pio_enable_in && pb_cnt_r < need;  // see RULE_06
            status_r[`CHP_ST_PCHAN] <= side_bit(pb_cnt_r, eight_bit_mode_in, stereo_mode_in);  // see RULE_07
            status_r[`CHP_ST_PHALF] <= half_bit(pb_cnt_r, eight_bit_mode_in);   // see RULE_08
            status_r[`CHP_ST_SAMPLE_OVERRUN_UNDERRUN] <= sample_overrun_underrun_r;
            status_r[`CHP_ST_CAPTURE_BYTE_READY] <= cap_fresh_r;                              // see RULE_10
            status_r[`CHP_ST_CCHAN] <= side_bit(cap_cnt_r, eight_bit_mode_in, stereo_mode_in);  // see RULE_11
            status_r[`CHP_ST_CHALF] <= half_bit(cap_cnt_r, eight_bit_mode_in);  // see RULE_11
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data, latched once at the start of a read; a bit rising later shows next access

    logic [7:0] win_byte;

    always_comb begin
        case (indirect_index_out)
            `CHP_IX_LEFT_INPUT: win_byte = left_input_r;
            `CHP_IX_RIGHT_INPUT: win_byte = right_input_r;
            `CHP_IX_LEFT_AUX1: win_byte = left_aux1_r;
            `CHP_IX_RIGHT_AUX1: win_byte = right_aux1_r;
            default: win_byte = `CHP_UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            host_data_out <= 8'h00;
        end else if (rd_start) begin
            case (rd_sel)
                `CHP_SEL_INDEX: host_data_out <= init_busy_in ? `CHP_INIT_READ : {4'h0, indirect_index_out};
                `CHP_SEL_DATA: host_data_out <= init_busy_in ? `CHP_INIT_READ : win_byte;  // see RULE_01, see RULE_02
                `CHP_SEL_STATUS: host_data_out <= status_r;                     // see RULE_12
                `CHP_SEL_PIO: host_data_out <= init_busy_in ? `CHP_INIT_READ : cap_byte;   // see RULE_14, see RULE_15
                default: host_data_out <= 8'h00;
            endcase
        end
    end

endmodule

//--- testbench/chp_port_monitor.sv
// concurrent checks on the pins of the codec host register port
`timescale 1ns/10ps
module chp_port_monitor (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // watched pins
    input wire logic host_cs_n_in,
    input wire logic host_rd_n_in,
    input wire logic host_wr_n_in,
    input wire logic [1:0] register_select_lines_in,
    input wire logic [7:0] host_data_out,
    input wire logic host_data_oe_out,
    input wire logic irq_out,
    input wire logic init_busy_in,
    input wire logic irq_pin_gate_in,
    input wire logic counter_underflow_in,
    input wire logic playback_take_in,
    input wire logic [15:0] playback_left_out,
    input wire logic [3:0] indirect_index_out,
    input wire logic [4:0] left_aux1_level_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    // cycles since the read strobe was last seen low
    logic [2:0] since_rd_r;
    always_ff @(posedge clock_in) begin
        if (!rst_n_in || !host_rd_n_in) begin
            since_rd_r <= 3'h0;
        end else if (since_rd_r != 3'h7) begin
            since_rd_r <= since_rd_r + 3'h1;
        end
    end
    ////////////////////////////////////////////////////////////////
    sequence read_held;
        (!host_rd_n_in && !host_cs_n_in)[*6];
    endsequence
    sequence underflow_gated;
        counter_underflow_in && irq_pin_gate_in ##1 irq_pin_gate_in;
    endsequence
    sequence flag_quiet;
        (irq_out && irq_pin_gate_in && host_wr_n_in)[*5] ##1 irq_pin_gate_in;
    endsequence
    read_drive_a: assert property (read_held |-> host_data_oe_out)
        else $error("bus not driven during a read");
    oe_release_a: assert property (host_data_oe_out |-> since_rd_r <= 3'h5)
        else $error("bus driven after the read ended");
    init_read_a: assert property ((init_busy_in && register_select_lines_in != 2'h2 && !host_rd_n_in
        && !host_cs_n_in)[*6] |-> host_data_out == 8'h80)
        else $error("read while initializing not 80");
    irq_gate_a: assert property (irq_out |-> $past(irq_pin_gate_in))
        else $error("interrupt pin active while gated off");
    underflow_irq_a: assert property (underflow_gated |-> ##[1:2] irq_out)
        else $error("underflow raised no interrupt");
    irq_sticky_a: assert property (flag_quiet |-> irq_out)
        else $error("interrupt dropped without a status write");
    index_write_a: assert property ($changed(indirect_index_out) |-> $past(host_wr_n_in)
        && $past(host_wr_n_in, 3))
        else $error("index changed without a write");
    aux_write_a: assert property ($changed(left_aux1_level_out) |-> $past(host_wr_n_in)
        && !$past(init_busy_in))
        else $error("aux level changed without a write");
    playback_hold_a: assert property (!$past(playback_take_in) |-> $stable(playback_left_out))
        else $error("playback sample changed without a take");
endmodule
bind chp_codec_host_port chp_port_monitor u_mon (.clock_in, .rst_n_in, .host_cs_n_in, .host_rd_n_in,
    .host_wr_n_in, .register_select_lines_in, .host_data_out, .host_data_oe_out, .irq_out, .init_busy_in,
    .irq_pin_gate_in, .counter_underflow_in, .playback_take_in, .playback_left_out, .indirect_index_out,
    .left_aux1_level_out);

//--- testbench/chp_host_model.sv
// host bus controller model making byte register accesses
`timescale 1ns/10ps
module chp_host_model (
    // clock
    input wire logic clock_in,
    // bus pins toward the port
    output logic cs_n_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic [1:0] sel_out,
    output logic [7:0] data_out,
    input wire logic [7:0] data_in,
    input wire logic data_oe_in,
    // read results
    output logic rd_done_out,
    output logic [7:0] rd_data_out,
    output logic timed_out_out
);
    initial begin
        cs_n_out = 1'b1;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        sel_out = 2'h0;
        data_out = 8'h5A;
        rd_done_out = 1'b0;
        rd_data_out = 8'h00;
        timed_out_out = 1'b0;
    end
    // released data lines show the inverse of the last byte, so a release after the first read following a write shows that written byte again
    task automatic release_bus();
        cs_n_out = 1'b1;
        data_out = ~data_out;
        repeat (6) @(negedge clock_in);
    endtask
    task automatic write_reg(input logic [1:0] sel, input logic [7:0] val);
        @(negedge clock_in);
        cs_n_out = 1'b0;
        sel_out = sel;
        data_out = val;
        wr_n_out = 1'b0;
        repeat (4) @(negedge clock_in);
        wr_n_out = 1'b1;
        repeat (3) @(negedge clock_in);
        release_bus();
    endtask
    task automatic read_reg(input logic [1:0] sel);
        int n;
        n = 0;
        @(negedge clock_in);
        cs_n_out = 1'b0;
        sel_out = sel;
        rd_n_out = 1'b0;
        repeat (6) @(negedge clock_in);
        while (data_oe_in !== 1'b1 && n < 10) begin
            @(negedge clock_in);
            n++;
        end
        timed_out_out = (n == 10);
        rd_data_out = data_in;
        rd_done_out = 1'b1;
        @(negedge clock_in);
        rd_done_out = 1'b0;
        rd_n_out = 1'b1;
        release_bus();
    endtask
endmodule

//--- testbench/chp_codec_host_port_bench.sv
// self-checking bench of the codec host register port
`timescale 1ns/10ps
module chp_codec_host_port_bench;
    logic clock_in, rst_n_in, host_cs_n_in, host_rd_n_in, host_wr_n_in, host_data_oe_out, irq_out;
    logic init_busy_in, irq_pin_gate_in, counter_underflow_in, eight_bit_mode_in, stereo_mode_in;
    logic playback_pio_enable_in, capture_pio_enable_in, capture_overrun_flag_in, playback_underrun_flag_in;
    logic sample_tick_in, capture_sample_in, playback_take_in, rd_done, timed_out;
    logic left_mic_boost_out, right_mic_boost_out, left_aux1_mute_out, right_aux1_mute_out;
    logic [1:0] register_select_lines_in, left_source_select_out, right_source_select_out;
    logic [3:0] indirect_index_out, left_input_gain_out, right_input_gain_out;
    logic [4:0] left_aux1_level_out, right_aux1_level_out;
    logic [7:0] host_data_in, host_data_out, rd_data, v, b[5];
    logic [7:0] exp_q[$];
    logic [7:0] exp_w[4];
    logic [15:0] capture_left_in, capture_right_in, playback_left_out, playback_right_out;
    int n_fail, tests_run, seed;
    chp_codec_host_port uut (.*);
    chp_host_model host (.clock_in, .cs_n_out(host_cs_n_in), .rd_n_out(host_rd_n_in),
        .wr_n_out(host_wr_n_in), .sel_out(register_select_lines_in), .data_out(host_data_in),
        .data_in(host_data_out), .data_oe_in(host_data_oe_out), .rd_done_out(rd_done),
        .rd_data_out(rd_data), .timed_out_out(timed_out));
    always #50 clock_in = ~clock_in;
    ////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        tests_run++;
        if (seen !== want) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic rd(input logic [1:0] sel, input logic [7:0] want);
        exp_q.push_back(want);
        host.read_reg(sel);
    endtask
    task automatic ixw(input logic [3:0] ix, input logic [7:0] val);
        host.write_reg(2'h0, {4'h0, ix});
        host.write_reg(2'h1, val);
    endtask
    task automatic ixr(input logic [3:0] ix, input logic [7:0] want);
        host.write_reg(2'h0, {4'h0, ix});
        rd(2'h1, want);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clock_in);
        s = 1'b1;
        @(negedge clock_in);
        s = 1'b0;
        repeat (3) @(negedge clock_in);
    endtask
    // read results are matched against the oldest note
    always @(posedge clock_in) begin
        if (rd_done === 1'b1) begin
            check(rd_data, exp_q.pop_front());
        end
    end
    always @(posedge timed_out) begin
        n_fail++;
        give_verdict();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        {clock_in, rst_n_in, init_busy_in, irq_pin_gate_in, counter_underflow_in, stereo_mode_in} = 6'h0;
        {playback_pio_enable_in, capture_pio_enable_in, capture_overrun_flag_in} = 3'h0;
        {playback_underrun_flag_in, sample_tick_in, capture_sample_in, playback_take_in} = 4'h0;
        eight_bit_mode_in = 1'b1;
        capture_left_in = 16'h0;
        capture_right_in = 16'h0;
        n_fail = 0;
        tests_run = 0;
        seed = 25098;
        repeat (8) @(negedge clock_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge clock_in);
        rd(2'h2, 8'hCC);
        for (int i = 0; i < 4; i++) ixr(i[3:0], i < 2 ? 8'h00 : 8'h80);
        for (int i = 0; i < 4; i++) begin
            ixw(4'h0, {i[1:0], 6'h25});
            check(left_source_select_out, i[1:0]);
        end
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            exp_w[i] = v & (i < 2 ? 8'hEF : 8'h9F);
            ixw(i[3:0], exp_w[i]);
            ixr(i[3:0], exp_w[i]);
        end
        check({left_source_select_out, left_mic_boost_out, 1'b0, left_input_gain_out}, exp_w[0]);
        check({right_source_select_out, right_mic_boost_out, 1'b0, right_input_gain_out}, exp_w[1]);
        check({left_aux1_mute_out, 2'h0, left_aux1_level_out}, exp_w[2]);
        check({right_aux1_mute_out, 2'h0, right_aux1_level_out}, exp_w[3]);
        rd(2'h0, 8'h03);
        ixw(4'h5, 8'hFF);
        ixr(4'h5, 8'h00);
        host.write_reg(2'h0, 8'h03);
        init_busy_in = 1'b1;
        rd(2'h1, 8'h80);
        host.write_reg(2'h1, 8'h1F);
        rd(2'h3, 8'h80);
        init_busy_in = 1'b0;
        rd(2'h1, exp_w[3]);
        irq_pin_gate_in = 1'b1;
        pulse(counter_underflow_in);
        check(irq_out, 1'b1);
        rd(2'h2, 8'hCD);
        irq_pin_gate_in = 1'b0;
        repeat (3) @(negedge clock_in);
        check(irq_out, 1'b0);
        rd(2'h2, 8'hCD);
        irq_pin_gate_in = 1'b1;
        host.write_reg(2'h2, 8'($random(seed)));
        rd(2'h2, 8'hCC);
        check(irq_out, 1'b0);
        {eight_bit_mode_in, stereo_mode_in, playback_pio_enable_in} = 3'b011;
        for (int i = 0; i < 5; i++) begin
            b[i] = 8'($random(seed));
            host.write_reg(2'h3, b[i]);
        end
        pulse(playback_take_in);
        check(playback_left_out, {b[1], b[0]});
        check(playback_right_out, {b[3], b[2]});
        capture_pio_enable_in = 1'b1;
        capture_left_in = 16'($random(seed));
        capture_right_in = 16'($random(seed));
        pulse(capture_sample_in);
        rd(2'h2, 8'h66);
        rd(2'h3, capture_left_in[7:0]);
        rd(2'h3, capture_left_in[15:8]);
        rd(2'h2, 8'h26);
        rd(2'h3, capture_right_in[7:0]);
        rd(2'h3, capture_right_in[15:8]);
        rd(2'h3, capture_right_in[15:8]);
        rd(2'h2, 8'h86);
        host.write_reg(2'h3, b[4]);
        rd(2'h2, 8'h8E);
        {capture_overrun_flag_in, playback_underrun_flag_in} = 2'b01;
        pulse(sample_tick_in);
        rd(2'h2, 8'h9E);
        {capture_overrun_flag_in, playback_underrun_flag_in} = 2'b10;
        pulse(sample_tick_in);
        rd(2'h2, 8'h9E);
        capture_overrun_flag_in = 1'b0;
        pulse(sample_tick_in);
        rd(2'h2, 8'h8E);
        // 8-bit stereo capture: upper byte of each word, left then right
        {eight_bit_mode_in, stereo_mode_in} = 2'b11;
        pulse(capture_sample_in);
        rd(2'h2, 8'hEA);
        rd(2'h3, capture_left_in[15:8]);
        rd(2'h3, capture_right_in[15:8]);
        rd(2'h2, 8'h8A);
        repeat (4) @(negedge clock_in);
        give_verdict();
    end
endmodule
